// ---- core/serial_send_mailbox.v ----
// Purpose: Transmit side of an asynchronous serial port fed from a send mailbox
// Assumes: Software keeps the mailbox handshake; one clock mclk at 20 MHz
// Notes: Two interfaces share one mailbox; each has its own control byte and line
//
// Behaviour
// - Payload bytes stored from byte 0 and sent in that order.
// - Device clears bit 7 when the send is finished.
// - Device sets bit 0 when a send fails.
// - One parity bit generated per transmitted character, except in the 8-bit format without parity.
// - Formats: 7 bits even parity, 8 bits even or none.
// - Second interface works alike with its own control byte.
// - Error writes a nonzero code into control bits 0 to 6.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "serial_send_regs.vh"

module serial_send_mailbox (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Avalon-MM slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Send triggers, one-cycle pulses from the program side
    input wire send_trigger,
    input wire second_send_trigger,
    // Serial lines
    output reg txd,
    output reg second_txd
);

    // ==========================================================
    // State
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SEND = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    reg [7:0] mbx_r [0:`MBX_DEPTH-1];
    reg [7:0] send_ctrl_r;
    reg [7:0] send2_ctrl_r;
    reg [2:0] format_r;
    reg [15:0] baud_div_r;
    reg [15:0] length_r;
    reg [2:0] state_r;
    reg chan_r;
    reg [15:0] baud_cnt_r;
    reg [3:0] bit_idx_r;
    reg [10:0] shift_r;
    reg [3:0] nbits_r;
    reg [15:0] sent_r;
    reg pend_r;
    reg pend2_r;
    reg ack_r;
    reg [31:0] rdata_nxt;

    wire acc = avs_read | avs_write;
    // Write lands only at the accepting edge, waitrequest low
    wire wr_now = avs_write & ~avs_waitrequest;
    wire in_mbx = (avs_address >= `OFS_PAYLOAD);
    wire [`MBX_AW-1:0] mbx_idx = avs_address[`MBX_AW-1:0];
    wire baud_tick = (baud_cnt_r == 16'h0000);
    wire [6:0] wr_len_lo = avs_writedata[6:0];

    // ==========================================================
    // Read data mux
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (in_mbx) begin
            rdata_nxt[7:0] = mbx_r[mbx_idx];
        end else begin
            case (avs_address)
                `OFS_SEND_CTRL: rdata_nxt[7:0] = send_ctrl_r;
                `OFS_SEND2_CTRL: rdata_nxt[7:0] = send2_ctrl_r;
                `OFS_FORMAT: rdata_nxt[2:0] = format_r;
                `OFS_BAUD_DIV: rdata_nxt[15:0] = baud_div_r;
                `OFS_LENGTH: rdata_nxt[15:0] = length_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Bus answer: one wait cycle, then accept
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(acc & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= rdata_nxt;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `MBX_DEPTH; gi = gi + 1) begin : g_mbx
            always @(posedge mclk) begin
                if (wr_now && in_mbx && mbx_idx == gi && avs_byteenable[0]) begin
                    mbx_r[gi] <= avs_writedata[7:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Configuration registers
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            format_r <= `FMT_RESET;
            baud_div_r <= `BAUD_DIV_RESET;
            length_r <= 16'h0000;
        end else if (wr_now) begin
            case (avs_address)
                `OFS_FORMAT: format_r <= avs_writedata[2:0];
                `OFS_BAUD_DIV: baud_div_r <= avs_writedata[15:0];
                `OFS_LENGTH: length_r <= avs_writedata[15:0];
                default: length_r <= length_r;
            endcase
        end
    end

    // Trigger latches, taken only while the control byte shows busy
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pend_r <= 1'b0;
            pend2_r <= 1'b0;
        end else begin
            if (send_trigger && send_ctrl_r[`CTRL_BUSY_BIT] && format_r[`FMT_IFACE_EN_BIT]) begin
                pend_r <= 1'b1;
            end else if (ack_r && !chan_r) begin
                pend_r <= 1'b0;
            end
            if (second_send_trigger && send2_ctrl_r[`CTRL_BUSY_BIT] && format_r[`FMT_IFACE_EN_BIT]) begin
                pend2_r <= 1'b1;
            end else if (ack_r && chan_r) begin
                pend2_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Transmit engine
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            chan_r <= 1'b0;
            baud_cnt_r <= 16'h0000;
            bit_idx_r <= 4'h0;
            shift_r <= 11'h7FF;
            nbits_r <= 4'h0;
            sent_r <= 16'h0000;
            ack_r <= 1'b0;
            txd <= 1'b1;
            second_txd <= 1'b1;
        end else begin
            ack_r <= 1'b0;
            baud_cnt_r <= baud_tick ? baud_div_r : baud_cnt_r - 16'h0001;
            case (state_r)
                ST_IDLE: begin
                    // Skip the cycle that clears the finished request, else it restarts
                    if (!ack_r && (pend_r | pend2_r)) begin
                        chan_r <= ~pend_r;
                        sent_r <= 16'h0000;
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (sent_r == length_r || length_r > `MBX_DEPTH) begin
                        ack_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end else if (baud_tick) begin
                        if (format_r[`FMT_SEVEN_BIT]) begin
                            shift_r <= {2'b11, ^mbx_r[sent_r[6:0]][6:0], mbx_r[sent_r[6:0]][6:0], 1'b0};
                            nbits_r <= 4'd10;
                        end else if (format_r[`FMT_PAR_EN_BIT]) begin
                            shift_r <= {1'b1, ^mbx_r[sent_r[6:0]], mbx_r[sent_r[6:0]], 1'b0};
                            nbits_r <= 4'd11;
                        end else begin
                            shift_r <= {2'b11, mbx_r[sent_r[6:0]], 1'b0};
                            nbits_r <= 4'd10;
                        end
                        bit_idx_r <= 4'h0;
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (baud_tick) begin
                        if (bit_idx_r == nbits_r) begin
                            sent_r <= sent_r + 16'h0001;
                            state_r <= ST_WAIT;
                        end else begin
                            if (chan_r) second_txd <= shift_r[0];
                            else txd <= shift_r[0];
                            shift_r <= {1'b1, shift_r[10:1]};
                            bit_idx_r <= bit_idx_r + 4'h1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Control bytes: software writes, hardware clears busy and flags errors
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            send_ctrl_r <= 8'h00;
            send2_ctrl_r <= 8'h00;
        end else begin
            if (wr_now && avs_address == `OFS_SEND_CTRL && avs_byteenable[0]) begin
                send_ctrl_r <= avs_writedata[7:0];
            end
            if (wr_now && avs_address == `OFS_SEND2_CTRL && avs_byteenable[0]) begin
                send2_ctrl_r <= avs_writedata[7:0];
            end
            if (ack_r) begin
                if (!chan_r) begin
                    send_ctrl_r[`CTRL_BUSY_BIT] <= 1'b0;
                    if (length_r > `MBX_DEPTH) send_ctrl_r[6:0] <= `ERR_LENGTH;
                end else begin
                    send2_ctrl_r[`CTRL_BUSY_BIT] <= 1'b0;
                    if (length_r > `MBX_DEPTH) send2_ctrl_r[6:0] <= `ERR_LENGTH;
                end
            end
        end
    end

endmodule // serial_send_mailbox
`default_nettype wire

// ---- core/serial_send_regs.vh ----
// Purpose: Register map, field positions and timing counts of the serial send mailbox
// Assumes: 32-bit Avalon-MM, byte addresses, 20 MHz clock
// Notes: Definitions only
`ifndef SERIAL_SEND_REGS_VH
`define SERIAL_SEND_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_SEND_CTRL 8'h00
`define OFS_SEND2_CTRL 8'h04
`define OFS_FORMAT 8'h08
`define OFS_BAUD_DIV 8'h0C
`define OFS_LENGTH 8'h10
`define OFS_PAYLOAD 8'h80
`define OFS_PAYLOAD_END 8'hFF

// ==========================================================
// Control byte fields
`define CTRL_BUSY_BIT 7
`define CTRL_ERR_LSB 0
`define CTRL_ERR_MSB 6
// Length error code; odd, so the failure flag in bit 0 is set with it
`define ERR_LENGTH 7'h1D

// ==========================================================
// Format register fields
`define FMT_PAR_EN_BIT 0
`define FMT_SEVEN_BIT 1
`define FMT_IFACE_EN_BIT 2
`define FMT_RESET 3'h1

// ==========================================================
// Mailbox and timing
`define MBX_DEPTH 128
`define MBX_AW 7
`define BAUD_DIV_RESET 16'h0823

`endif

// ---- tb/serial_line_partner.sv ----
// Purpose: Serial receiver at the far end of one send line
// Assumes: Bit period of 2*half clocks, one stop bit
// Notes: Reports each character with a one-cycle strobe
`timescale 1ns/1ns
`default_nettype none
module serial_line_partner (
    // Clock and line
    input wire logic mclk,
    input wire logic line,
    // Character format
    input var int half,
    input var int nbits,
    input wire logic par,
    // Received character
    output logic [7:0] got,
    output logic got_ok,
    output logic got_v = 1'b0
);
    // ==========
    // Mid-bit sampling of one frame
    always begin
        logic p;
        @(negedge line);
        repeat (half) @(posedge mclk);
        got = 8'h00;
        p = 1'b0;
        for (int i = 0; i < nbits + par; i++) begin
            repeat (2 * half) @(posedge mclk);
            if (i < nbits) got[i] = line;
            p = p ^ line;
        end
        repeat (2 * half) @(posedge mclk);
        got_ok = (!par || !p) && line;
        got_v <= 1'b1;
        @(posedge mclk);
        got_v <= 1'b0;
    end
endmodule // serial_line_partner
`default_nettype wire

// ---- tb/serial_send_mailbox_properties.sv ----
// Purpose: Port checks of the serial send mailbox
// Assumes: Bus answer one cycle after a request is seen
// Notes: Bound to the design module
`timescale 1ns/1ns
`default_nettype none
module serial_send_mailbox_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Triggers and lines
    input wire logic send_trigger,
    input wire logic second_send_trigger,
    input wire logic txd,
    input wire logic second_txd
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic armed_r, armed2_r;
    wire rd_ok = avs_read && !avs_waitrequest;
    // Triggers seen since reset
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            armed_r <= 1'b0;
            armed2_r <= 1'b0;
        end else begin
            armed_r <= armed_r | send_trigger;
            armed2_r <= armed2_r | second_send_trigger;
        end
    end
    // ==========
    // Assertions
    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("late answer");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long accept");
    chk_unmapped_zero: assert property (rd_ok && avs_address == 8'h14 |-> avs_readdata == 32'h0)
        else $error("unmapped data");
    chk_reset_idle: assert property (!$past(arst_n) |-> txd && second_txd && avs_waitrequest)
        else $error("not idle");
    chk_tx_cause: assert property ($fell(txd) |-> armed_r)
        else $error("frame unasked");
    chk_tx2_cause: assert property ($fell(second_txd) |-> armed2_r)
        else $error("frame2 unasked");
    chk_one_line: assert property (txd || second_txd)
        else $error("both lines low");
    chk_busy_seen: assert property (rd_ok && avs_address == 8'h00 && !txd |-> avs_readdata[7])
        else $error("busy lost");
    chk_busy2_seen: assert property (rd_ok && avs_address == 8'h04 && !second_txd |-> avs_readdata[7])
        else $error("busy2 lost");
    cover property ($fell(txd));
    cover property ($fell(second_txd));
    cover property (rd_ok && avs_address == 8'h00 && avs_readdata[6:0] != 7'h00);
endmodule // serial_send_mailbox_properties
bind serial_send_mailbox serial_send_mailbox_properties serial_send_mailbox_properties_i (
    .mclk(mclk),
    .arst_n(arst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .send_trigger(send_trigger),
    .second_send_trigger(second_send_trigger),
    .txd(txd),
    .second_txd(second_txd)
);
`default_nettype wire

// ---- tb/serial_send_mailbox_bench.sv ----
// Purpose: Self-checking bench of the serial send mailbox
// Assumes: Divider set to 15, so a bit lasts 16 clocks
// Notes: Expected characters wait in a queue for the watcher
`timescale 1ns/1ns
`default_nettype none
`include "serial_send_regs.vh"
module serial_send_mailbox_bench;
    logic mclk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, par = 1'b0;
    logic send_trigger = 1'b0, second_send_trigger = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    wire avs_waitrequest, txd, second_txd, v1, v2, ok1, ok2;
    wire [7:0] g1, g2;
    logic [8:0] expq[$];
    int error_cnt = 0, checked = 0, nb = 8, seed = 32'hbdf5;
    always #25 mclk = ~mclk;
    serial_send_mailbox serial_send_mailbox_i (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .send_trigger(send_trigger), .second_send_trigger(second_send_trigger), .txd(txd),
        .second_txd(second_txd));
    serial_line_partner serial_line_partner_i (.mclk(mclk), .line(txd), .half(8), .nbits(nb), .par(par),
        .got(g1), .got_ok(ok1), .got_v(v1));
    serial_line_partner serial_line_partner_b_i (.mclk(mclk), .line(second_txd), .half(8), .nbits(nb),
        .par(par), .got(g2), .got_ok(ok2), .got_v(v2));
    // ==========
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic pulse(input logic ch);
        @(posedge mclk);
        send_trigger <= !ch;
        second_send_trigger <= ch;
        @(posedge mclk);
        send_trigger <= 1'b0;
        second_send_trigger <= 1'b0;
    endtask
    task automatic send(input logic ch, input int len);
        logic [7:0] b;
        // Mailbox touched only while busy reads zero
        bus(1'b0, ch ? `OFS_SEND2_CTRL : `OFS_SEND_CTRL, 32'h0);
        chk("free", q[`CTRL_BUSY_BIT], 1'b0);
        bus(1'b1, `OFS_LENGTH, 32'(len));
        for (int i = 0; i < len && len <= `MBX_DEPTH; i++) begin
            b = 8'($random(seed));
            if (nb == 7) b[7] = 1'b0;
            expq.push_back({ch, b});
            bus(1'b1, 8'(`OFS_PAYLOAD + i), 32'(b));
        end
        bus(1'b1, ch ? `OFS_SEND2_CTRL : `OFS_SEND_CTRL, 32'h80);
        pulse(ch);
        // Poll busy, result then in bit 0
        do bus(1'b0, ch ? `OFS_SEND2_CTRL : `OFS_SEND_CTRL, 32'h0); while (q[7] !== 1'b0);
    endtask
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Oldest note against each received character
    always @(posedge mclk) begin
        if (v1 || v2) begin
            chk("char", {v2, v2 ? g2 : g1}, expq.size() > 0 ? expq.pop_front() : 32'hFFFFFFFF);
            chk("frame", v2 ? ok2 : ok1, 1'b1);
        end
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end
    // ==========
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (i == 4) continue;
            bus(1'b0, 8'(i * 4), 32'h0);
            chk("reset", q, i == 2 ? `FMT_RESET : i == 3 ? `BAUD_DIV_RESET : 0);
        end
        bus(1'b1, `OFS_BAUD_DIV, 32'hF);
        // Each format once, the middle one on the second line
        for (int f = 0; f < 3; f++) begin
            nb = f == 2 ? 7 : 8;
            par = f != 0;
            bus(1'b1, `OFS_FORMAT, 32'(4 + f));
            send(f == 1, 1 + {$random(seed)} % 4);
            chk("done", q, 32'h0);
        end
        bus(1'b1, `OFS_LENGTH, 32'h2);
        pulse(1'b0);
        repeat (400) @(posedge mclk);
        bus(1'b0, `OFS_SEND_CTRL, 32'h0);
        chk("ignored", q, 32'h0);
        send(1'b0, 129);
        chk("error", q, 32'(`ERR_LENGTH));
        chk("error flag", q[`CTRL_ERR_LSB], 1'b1);
        bus(1'b1, `OFS_SEND_CTRL, 32'h0);
        bus(1'b0, `OFS_SEND_CTRL, 32'h0);
        chk("cleared", q, 32'h0);
        chk("left", expq.size(), 32'h0);
        results();
    end
endmodule // serial_send_mailbox_bench
`default_nettype wire
